// [include/dbwc_pkg.sv]
// Package for the DMA bus width converter: states, strobe groups and timing constants
package dbwc_pkg;

	// Timing of the converter's own system clock, which is derived from the fast clock
	localparam int CLK_PERIOD_NS = 10;
	localparam int SYS_PERIOD_NS = 40;
	localparam int SYS_DIV = (SYS_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SYS_HALF = SYS_DIV / 2;
	localparam logic [1:0] DIV_LAST = 2'(SYS_DIV - 1);
	localparam logic [1:0] DIV_HALF = 2'(SYS_HALF);
	localparam logic [1:0] DIV_RESET = 2'h0;

	// Number of external inputs that pass through the synchroniser
	localparam int SYNC_WIDTH = 9;
	localparam logic [SYNC_WIDTH-1:0] SYNC_RESET = 9'h000;

	// Sequencer time partitions, one per system clock period
	typedef enum logic [2:0]
	{
		ST_T1 = 3'b000,
		ST_T2 = 3'b001,
		ST_TW1 = 3'b010,
		ST_TW2 = 3'b011,
		ST_RB2 = 3'b100,
		ST_PASS = 3'b101,
		ST_DONE = 3'b110,
		ST_TAIL = 3'b111
	} dbwc_state_type;

	localparam dbwc_state_type STATE_RESET = ST_T1;

	// Strobes coming from the DMA controller while it owns the bus
	typedef struct packed
	{
		logic ale;
		logic data_strobe;
		logic write_dir;
		logic byte_xfer;
	} dbwc_dma_in_type;

	// Strobes coming from the processor while it owns the bus
	typedef struct packed
	{
		logic rd;
		logic wr;
		logic sel;
	} dbwc_cpu_in_type;

	// Control outputs toward bus, port latch and transceiver
	typedef struct packed
	{
		logic rd;
		logic wr;
		logic dma_wait;
		logic pass_en;
		logic upper_clk_en;
		logic lower_drive;
		logic upper_drive;
		logic dma_data_strobe;
	} dbwc_ctl_type;

	localparam dbwc_ctl_type CTL_RESET = 8'h00;
	localparam logic LA0_RESET = 1'b0;

endpackage

// [hw/dbwc_converter.sv]
// DMA bus width converter: sequencer and strobe logic between a 16-bit DMA and an 8-bit bus
`timescale 1ns/1ps

// Function
// - Address latch strobe clears sequencer to zero
// - State one: read equals read-dir and strobe; wait
// - Byte read pass enable in second period, clock low
// - Latched address bit high in first period
// - Latched address bit valid before strobe falls
// - Word read: read strobe drops, returns; wait held
// - State two asserts upper-byte latch clock enable
// - Upper byte capture lands in state three
// - Latched address bit low before second read
// - Pass enable after second byte read
// - Wait released at end of word read
// - Word write: lower drive off, upper drive on
// - Processor master: address bit transparent under strobe
module dbwc_converter
	import dbwc_pkg::*;
(
	input wire logic clock, // Fast design clock
	input wire logic reset, // Synchronous, active high
	input wire logic hlda_pin, // DMA controller owns the bus
	input wire logic addr_bit0_pin, // Raw address bit 0 from current master
	input wire dbwc_dma_in_type dma_pins, // DMA strobes, asynchronous
	input wire dbwc_cpu_in_type cpu_pins, // Processor strobes, asynchronous
	output logic sys_clk, // Derived system clock driven to the bus
	output logic latched_addr_bit0, // System address bit 0
	output dbwc_ctl_type ctl, // Registered control strobes
	output logic bus_strobe_oe // High while read and write strobes are driven
);

	// Synchroniser stages; stage one feeds only stage two
	logic [SYNC_WIDTH-1:0] raw_in;
	logic [SYNC_WIDTH-1:0] sync1_q;
	logic [SYNC_WIDTH-1:0] sync2_q;

	// Divider for the system clock
	logic [1:0] div_q;
	logic sys_clk_q;
	logic sys_rise; // One-cycle pulse at each system rising edge
	logic ck_low; // Last clock of one system period and first clock of the next

	// Sequencer and outputs
	dbwc_state_type state_q;
	dbwc_ctl_type ctl_d;
	dbwc_ctl_type ctl_q;
	logic la0_d;
	logic la0_q;

	// Synchronised views of the inputs
	logic hlda;
	logic a0;
	dbwc_dma_in_type dma;
	dbwc_cpu_in_type cpu;
	logic word_xfer;
	logic rd_dir;

	assign raw_in = {hlda_pin, addr_bit0_pin, dma_pins, cpu_pins};

	// Two flip-flops per input bit; all pins are foreign to this clock
	genvar gi;
	generate
		for (gi = 0; gi < SYNC_WIDTH; gi++)
		begin : g_sync
			always_ff @(posedge clock)
			begin
				if (reset)
				begin
					sync1_q[gi] <= SYNC_RESET[gi];
					sync2_q[gi] <= SYNC_RESET[gi];
				end
				else
				begin
					sync1_q[gi] <= raw_in[gi];
					sync2_q[gi] <= sync1_q[gi];
				end
			end
		end
	endgenerate

	assign {hlda, a0, dma, cpu} = sync2_q;
	assign word_xfer = ~dma.byte_xfer;
	assign rd_dir = ~dma.write_dir;

	// System clock divider; high for the first half of each period
	always_ff @(posedge clock)
	begin
		if (reset)
		begin
			div_q <= DIV_RESET;
			sys_clk_q <= 1'b0;
		end
		else
		begin
			// Wrap at the end of the period
			if (div_q == DIV_LAST)
				div_q <= DIV_RESET;
			else
				div_q <= div_q + 2'h1;
			sys_clk_q <= (div_q == DIV_LAST) || (div_q < DIV_HALF - 2'h1);
		end
	end

	assign sys_rise = (div_q == DIV_RESET);
	// Registered sys_clk is high while div_q is 0 or 1; ck_low decodes div_q 3 then 0.
	// Using those two clocks keeps pass enable seamless across the state change.
	assign ck_low = (div_q > DIV_HALF) || sys_rise;

	// Sequencer: cleared by the latch strobe, otherwise counts system periods
	always_ff @(posedge clock)
	begin
		if (reset)
			state_q <= STATE_RESET;
		else if (dma.ale)
			state_q <= ST_T1;
		else if (sys_rise)
			state_q <= dbwc_state_type'(state_q + 3'h1);
	end

	// Control strobes for each time partition
	always_comb
	begin
		ctl_d = CTL_RESET;
		if (hlda)
		begin
			case (state_q)
				ST_T1:
				begin
					// Only the address bit is active here
					ctl_d = CTL_RESET;
				end
				ST_T2:
				begin
					ctl_d.rd = rd_dir & dma.data_strobe;
					ctl_d.dma_wait = 1'b1;
					ctl_d.pass_en = dma.byte_xfer & rd_dir & ck_low;
					ctl_d.wr = dma.write_dir & dma.data_strobe;
					ctl_d.lower_drive = dma.write_dir;
				end
				ST_TW1:
				begin
					ctl_d.rd = rd_dir & dma.data_strobe;
					ctl_d.upper_clk_en = word_xfer;
					ctl_d.pass_en = dma.byte_xfer & rd_dir;
					ctl_d.dma_wait = word_xfer;
					ctl_d.wr = dma.write_dir & dma.data_strobe;
					ctl_d.lower_drive = dma.write_dir;
				end
				ST_TW2:
				begin
					// Upper byte now sits in the port latch; first read strobe drops
					ctl_d.rd = dma.byte_xfer & rd_dir & dma.data_strobe;
					ctl_d.pass_en = dma.byte_xfer & rd_dir;
					ctl_d.dma_wait = word_xfer;
					ctl_d.wr = dma.byte_xfer & dma.write_dir & dma.data_strobe;
				end
				ST_RB2:
				begin
					// Second byte: read strobe returns after the address bit went low
					ctl_d.rd = rd_dir & dma.data_strobe;
					ctl_d.pass_en = dma.byte_xfer & rd_dir;
					ctl_d.dma_wait = word_xfer;
					ctl_d.wr = dma.write_dir & dma.data_strobe;
					ctl_d.lower_drive = dma.byte_xfer & dma.write_dir;
					ctl_d.upper_drive = word_xfer & dma.write_dir;
				end
				ST_PASS:
				begin
					// Latched upper byte and live lower byte reach the DMA together
					ctl_d.rd = rd_dir & dma.data_strobe;
					ctl_d.pass_en = rd_dir & (dma.byte_xfer | ck_low);
					ctl_d.dma_wait = word_xfer;
					ctl_d.wr = dma.write_dir & dma.data_strobe;
					ctl_d.upper_drive = word_xfer & dma.write_dir;
				end
				ST_DONE:
				begin
					// Wait released so the DMA strobes all sixteen bits in
					ctl_d.rd = rd_dir & dma.data_strobe;
					ctl_d.pass_en = rd_dir;
					ctl_d.dma_wait = 1'b0;
				end
				ST_TAIL:
				begin
					ctl_d.rd = rd_dir & dma.data_strobe;
					ctl_d.pass_en = rd_dir & dma.data_strobe;
				end
				default:
				begin
					ctl_d = CTL_RESET;
				end
			endcase
		end
		else
		begin
			// Processor is master; lanes steered by the latched address bit
			ctl_d.upper_clk_en = la0_q & cpu.wr & cpu.sel;
			ctl_d.pass_en = ~la0_q & cpu.wr & cpu.sel;
			ctl_d.lower_drive = ~la0_q & cpu.rd & cpu.sel;
			ctl_d.upper_drive = la0_q & cpu.rd & cpu.sel;
			// Only the second (even) byte of a write, or an even-byte read, strobes the DMA; host keeps order
			ctl_d.dma_data_strobe = ctl_d.pass_en | ctl_d.lower_drive;
		end
	end

	// Latched address bit 0 next value
	always_comb
	begin
		la0_d = la0_q;
		if (hlda)
		begin
			if (word_xfer)
			begin
				// Odd byte first, even byte second
				if (dma.ale || state_q == ST_T1)
					la0_d = 1'b1;
				else if (state_q >= ST_TW2)
					la0_d = 1'b0;
			end
			else if (dma.ale)
				la0_d = a0;
		end
		else if (dma.ale && cpu.sel)
			la0_d = a0;
	end

	// Output registers: every strobe comes from a flip-flop
	always_ff @(posedge clock)
	begin
		if (reset)
		begin
			ctl_q <= CTL_RESET;
			la0_q <= LA0_RESET;
		end
		else
		begin
			ctl_q <= ctl_d;
			la0_q <= la0_d;
		end
	end

	assign ctl = ctl_q;
	assign latched_addr_bit0 = la0_q;
	assign sys_clk = sys_clk_q;
	assign bus_strobe_oe = hlda; // Processor drives the bus strobes otherwise

endmodule // dbwc_converter

// [verif/dbwc_dma_model.sv]
// Behavioural DMA controller running one bus cycle per request
`timescale 1ns/1ps
module dbwc_dma_model
	import dbwc_pkg::*;
(
	input wire logic clock,
	input wire logic reset,
	input wire logic go, // Start one cycle
	input wire logic abort, // Cut the cycle short
	input wire logic bw, // High for a byte transfer
	input wire logic rw, // High for a write
	input wire dbwc_ctl_type ctl,
	output dbwc_dma_in_type dma_pins,
	output logic busy
);
	logic [5:0] cnt_q; // Clocks since the address strobe fell
	// Strobe sequencing; a real controller stalls while wait is high
	always_ff @(posedge clock)
		if (reset || abort || (busy && cnt_q > 6'h19 && !ctl.dma_wait))
		begin
			busy <= 1'b0;
			dma_pins <= {1'b1, 1'b0, rw, bw};
		end
		else if (go || busy)
		begin
			busy <= 1'b1;
			cnt_q <= go ? 6'h00 : cnt_q + 6'h01;
			dma_pins <= {1'b0, 1'b1, rw, bw};
		end
endmodule // dbwc_dma_model

// [verif/dbwc_converter_asserts.sv]
// Concurrent checks on the DMA bus width converter ports
`timescale 1ns/1ps
module dbwc_converter_asserts
	import dbwc_pkg::*;
(
	input wire logic clock,
	input wire logic reset,
	input wire logic hlda_pin,
	input wire logic addr_bit0_pin,
	input wire dbwc_dma_in_type dma_pins,
	input wire dbwc_cpu_in_type cpu_pins,
	input wire logic sys_clk,
	input wire logic latched_addr_bit0,
	input wire dbwc_ctl_type ctl,
	input wire logic bus_strobe_oe
);
	logic [2:0] up_q; // Clocks since reset, saturating
	// Synchronisers still hold reset values just after release
	always_ff @(posedge clock)
		if (reset)
			up_q <= 3'h0;
		else if (up_q != 3'h7)
			up_q <= up_q + 3'h1;
	wire ok = up_q == 3'h7;
	wire rdm = ok && bus_strobe_oe && !dma_pins.write_dir; // DMA read
	default clocking @(posedge clock); endclocking
	default disable iff (reset);
	// Read strobe off for one whole state, then back
	sequence rd_gap;
		!ctl.rd [*4] ##1 ctl.rd;
	endsequence
	a_ale_clears: assert property (rdm && $past(dma_pins.ale, 4)
		|-> !ctl.rd && !ctl.dma_wait) else $error("not cleared");
	a_wait_on_t2: assert property (rdm && $fell(dma_pins.ale)
		|-> ##[3:8] ctl.rd && ctl.dma_wait) else $error("no wait");
	a_rd_double: assert property (rdm && $fell(ctl.rd) && ctl.dma_wait
		|-> rd_gap) else $error("no second read");
	a_upper_en: assert property (rdm && ctl.upper_clk_en
		|-> ctl.dma_wait && ctl.rd && latched_addr_bit0) else $error("bad latch en");
	a_even_byte: assert property (rdm && $fell(ctl.upper_clk_en) && ctl.dma_wait
		|-> !ctl.rd && !latched_addr_bit0) else $error("bad capture");
	a_pass_wait: assert property (rdm && $rose(ctl.pass_en)
		|-> ctl.dma_wait) else $error("pass early");
	a_write_half: assert property (ok && bus_strobe_oe && dma_pins.write_dir
		&& !dma_pins.byte_xfer && $fell(ctl.lower_drive)
		|-> !ctl.upper_drive [*4] ##1 ctl.upper_drive) else $error("bad halves");
	a_cpu_a0: assert property (ok && !$past(hlda_pin, 3) && $past(dma_pins.ale, 3)
		&& $past(cpu_pins.sel, 3) |-> latched_addr_bit0 == $past(addr_bit0_pin, 3))
		else $error("a0 not passed");
endmodule // dbwc_converter_asserts

// [verif/dbwc_converter_bench.sv]
// Self-checking bench for the DMA bus width converter
`timescale 1ns/1ps
module dbwc_converter_bench
	import dbwc_pkg::*;
;
	logic clock = 1'b0;
	logic reset = 1'b1;
	logic hlda = 1'b1; // DMA owns the bus first
	logic a0 = 1'b0;
	dbwc_cpu_in_type cpu = 3'h0; // Only select and write are exercised
	logic go = 1'b0;
	logic abort = 1'b0;
	logic bw = 1'b0;
	logic rw = 1'b0;
	logic busy, sys_clk, la0, oe;
	dbwc_dma_in_type dma;
	dbwc_ctl_type ctl;
	int err_total = 0;
	int checks = 0;
	int nw, nu, nd; // Clocks seen with wait, latch enable, upper drive
	// Byte, write, expected wait, latch-enable and upper-drive clocks
	logic [19:0] rows [3] = '{20'h14100, 20'h84000, 20'h40008};
	dbwc_converter DUT (.clock(clock), .reset(reset), .hlda_pin(hlda), .addr_bit0_pin(a0),
		.dma_pins(dma), .cpu_pins(cpu), .sys_clk(sys_clk), .latched_addr_bit0(la0),
		.ctl(ctl), .bus_strobe_oe(oe));
	dbwc_dma_model u_dma (.clock(clock), .reset(reset), .go(go), .abort(abort),
		.bw(bw), .rw(rw), .ctl(ctl), .dma_pins(dma), .busy(busy));
	initial forever #5 clock = ~clock;
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checks++;
		if (got !== exp)
		begin
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
			err_total++;
		end
	endtask
	task automatic final_report();
		$display("Counts: %0d checks, %0d mismatches", checks, err_total);
		if (err_total == 0 && checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	// Ask the model for one cycle of the given kind
	task automatic start(input logic b, input logic w);
		@(posedge clock);
		bw <= b;
		rw <= w;
		go <= 1'b1;
		@(posedge clock);
		go <= 1'b0;
		@(posedge clock);
	endtask
	// Count strobes until the cycle ends and the pipeline drains
	task automatic wait_idle();
		int k = 0;
		nw = 0;
		nu = 0;
		nd = 0;
		for (int n = 0; k < 6; n++)
		begin
			@(negedge clock);
			nw += ctl.dma_wait;
			nu += ctl.upper_clk_en;
			nd += ctl.upper_drive;
			k += !busy;
			if (n == 200)
			begin
				err_total++;
				final_report();
			end
		end
	endtask
	initial
	begin
		repeat (5) @(negedge clock);
		chk({sys_clk, la0, 6'h00}, 8'h00);
		chk(ctl, CTL_RESET);
		@(posedge clock);
		reset <= 1'b0;
		repeat (6) @(posedge clock);
		for (int i = 0; i < 3; i++)
		begin
			start(rows[i][19], rows[i][18]);
			wait_idle();
			chk(8'(nd), {2'h0, rows[i][5:0]});
			if (rows[i][18] === 1'b0)
			begin
				chk(8'(nw), {2'h0, rows[i][17:12]});
				chk(8'(nu), {2'h0, rows[i][11:6]});
			end
			$display("Test %0d done", i);
		end
		hlda <= 1'b0;
		cpu <= 3'h1;
		a0 <= 1'b1;
		repeat (5) @(negedge clock);
		chk({7'h00, la0}, 8'h01);
		chk({7'h00, oe}, 8'h00);
		start(1'b0, 1'b0);
		a0 <= 1'b0;
		repeat (5) @(negedge clock);
		chk({7'h00, la0}, 8'h01);
		wait_idle();
		chk({7'h00, la0}, 8'h00);
		$display("Test processor done");
		// Slave write: host sends the odd byte first, then the even one
		cpu <= 3'h3;
		a0 <= 1'b1;
		repeat (5) @(negedge clock);
		chk({7'h00, ctl.dma_data_strobe}, 8'h00);
		a0 <= 1'b0;
		repeat (5) @(negedge clock);
		chk({7'h00, ctl.dma_data_strobe}, 8'h01);
		cpu <= 3'h1;
		$display("Test slave write done");
		hlda <= 1'b1;
		repeat (4) @(posedge clock);
		start(1'b1, 1'b0);
		repeat (12) @(posedge clock);
		abort <= 1'b1;
		@(posedge clock);
		abort <= 1'b0;
		repeat (5) @(negedge clock);
		chk({6'h00, ctl.rd, ctl.dma_wait}, 8'h00);
		wait_idle();
		$display("Test abort done");
		final_report();
	end
endmodule // dbwc_converter_bench
bind dbwc_converter dbwc_converter_asserts u_chk (.clock(clock), .reset(reset),
	.hlda_pin(hlda_pin), .addr_bit0_pin(addr_bit0_pin), .dma_pins(dma_pins),
	.cpu_pins(cpu_pins), .sys_clk(sys_clk), .latched_addr_bit0(latched_addr_bit0),
	.ctl(ctl), .bus_strobe_oe(bus_strobe_oe));
